// ===== design/dps_protect.sv
/*
 Protection and start interlock logic of a motor drive: wire-break
 timer, stop-key priority, start check, trip latches, protection word.
 Assumes status inputs come from pins (synchronised here) and a plain
 register port with read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_protect
	import dps_pkg::*;
#(
	parameter int unsigned TICK_CYCLES =
		`DPS_BREAK_UNIT_MS * 1000000 / `DPS_CLK_PERIOD_NS
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic fb_below_2ma,
	input wire logic stop_key,
	input wire logic alarm_reset_key,
	input wire logic alarm_reset_input,
	input wire logic link_enable_input,
	input wire logic local_select_input,
	input wire logic run_terminal,
	input wire logic run_keypad,
	input wire logic run_link,
	input wire logic motor_stopped,
	input wire logic heatsink_hot,
	input wire logic drive_overload,
	input wire logic supply_phase_loss,
	input wire logic output_phase_loss,
	input wire logic fan_locked,
	input wire logic brake_fault,
	input wire logic cap_worn_factory,
	input wire logic cap_worn_user,
	input wire logic cap_ontime_worn,
	output logic run_enable,
	output logic decel_stop,
	output logic coast_stop,
	output logic carrier_lower,
	output logic fan_on,
	output logic overheat_output,
	output logic lifetime_output,
	output logic enclosure_high_class,
	output logic alarm_history_clear_pulse,
	output logic operation_error_alarm,
	output logic wire_break_alarm,
	output logic input_phase_loss_alarm,
	output logic output_phase_loss_alarm,
	output logic heatsink_overheat_alarm,
	output logic drive_overload_alarm,
	output logic braking_alarm
);

	localparam int NIN = 19;

	logic [NIN-1:0] sync1_r;
	logic [NIN-1:0] sync2_r;
	logic [NIN-1:0] pins;
	logic s_fb_low, s_stop, s_rst_key, s_rst_in, s_le, s_loc;
	logic s_run_t, s_run_k, s_run_l, s_stopped, s_hot, s_ovl;
	logic s_in_pl, s_out_pl, s_fan, s_brk, s_cap_f, s_cap_u, s_cap_t;

	logic [15:0] break_time_r;
	logic [1:0] stop_sel_r;
	logic [7:0] prot_mode_r;
	logic [1:0] ctrl_r;
	logic hist_clr_r;

	dps_run_t run_state_r;
	dps_src_t src_r;
	dps_src_t src_nxt;
	logic stop_key_d_r;
	logic rst_d_r;
	logic power_on_chk_r;
	logic [31:0] tick_cnt_r;
	// Full width, so no break time can wrap the count
	logic [15:0] break_cnt_r;
	logic [5:0] trip_r;
	logic op_err_r;
	logic ovl_trip_r;

	logic tick;
	logic any_run;
	logic src_run;
	logic alarm_release;
	logic check_now;
	logic stop_prio_hit;
	logic fan_lock_seen;
	logic hot_event;
	logic carrier_mode;
	logic tripped;
	logic [5:0] trip_set;
	logic break_expired;

	assign pins = {fb_below_2ma, stop_key, alarm_reset_key, alarm_reset_input,
		link_enable_input, local_select_input, run_terminal, run_keypad,
		run_link, motor_stopped, heatsink_hot, drive_overload,
		supply_phase_loss, output_phase_loss, fan_locked, brake_fault,
		cap_worn_factory, cap_worn_user, cap_ontime_worn};

	// Shared address match of write and clear decode
	function automatic logic dps_hit(input logic [7:0] addr, input logic [7:0] ofs);
		dps_hit = (addr == ofs);
	endfunction

	// Only the second stage is read; the first may be metastable
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
		end
	end

	assign {s_fb_low, s_stop, s_rst_key, s_rst_in, s_le, s_loc, s_run_t,
		s_run_k, s_run_l, s_stopped, s_hot, s_ovl, s_in_pl, s_out_pl,
		s_fan, s_brk, s_cap_f, s_cap_u, s_cap_t} = sync2_r;

	// Register writes
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			break_time_r <= `DPS_RST_BREAK_TIME;
			stop_sel_r <= `DPS_RST_STOP_SEL;
			prot_mode_r <= `DPS_RST_PROT_MODE;
			ctrl_r <= `DPS_RST_CTRL;
		end
		else if (reg_wr)
		begin
			if (dps_hit(reg_addr, `DPS_OFS_BREAK_TIME))
				break_time_r <= reg_wdata[15:0];
			if (dps_hit(reg_addr, `DPS_OFS_STOP_SEL))
				stop_sel_r <= reg_wdata[1:0];
			if (dps_hit(reg_addr, `DPS_OFS_PROT_MODE))
				prot_mode_r <= reg_wdata[7:0];
			if (dps_hit(reg_addr, `DPS_OFS_CTRL))
				ctrl_r <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			hist_clr_r <= 1'b0;
		else
			hist_clr_r <= reg_wr && dps_hit(reg_addr, `DPS_OFS_HIST_CLR) && reg_wdata[0];
	end
	assign alarm_history_clear_pulse = hist_clr_r;

	// Read data, one cycle after strobe
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= '0;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				`DPS_OFS_BREAK_TIME: reg_rdata <= {16'h0000, break_time_r};
				`DPS_OFS_STOP_SEL: reg_rdata <= {30'h0, stop_sel_r};
				`DPS_OFS_PROT_MODE: reg_rdata <= {24'h0, prot_mode_r};
				`DPS_OFS_CTRL: reg_rdata <= {30'h0, ctrl_r};
				`DPS_OFS_STATUS: reg_rdata <= {18'h0, lifetime_output,
					overheat_output, fan_on, carrier_lower, run_state_r,
					op_err_r, ovl_trip_r, trip_r};
				default: reg_rdata <= '0;
			endcase
		end
		// Zero outside the answer cycle, so stale data never stands
		else
			reg_rdata <= '0;
	end

	// Run source select
	always_comb
	begin
		if (s_loc)
			src_nxt = DPS_SRC_KEY;
		else if (s_le)
			src_nxt = DPS_SRC_LINK;
		else
			src_nxt = DPS_SRC_TERM;
	end

	always_comb
	begin
		unique case (src_r)
			DPS_SRC_KEY: src_run = s_run_k;
			DPS_SRC_LINK: src_run = s_run_l;
			default: src_run = s_run_t;
		endcase
	end

	assign any_run = s_run_t | s_run_k | s_run_l;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			src_r <= DPS_SRC_TERM;
			stop_key_d_r <= 1'b0;
			rst_d_r <= 1'b0;
			power_on_chk_r <= 1'b1;
		end
		else
		begin
			src_r <= src_nxt;
			stop_key_d_r <= s_stop;
			rst_d_r <= s_rst_key | s_rst_in;
			power_on_chk_r <= 1'b0;
		end
	end

	// release by key or reset input
	assign alarm_release = (s_rst_key | s_rst_in) & ~rst_d_r;

	assign check_now = power_on_chk_r | alarm_release | (src_nxt != src_r);

	// bit0 stop priority, bit1 start check
	// stop key wins over remote run
	assign stop_prio_hit = stop_sel_r[`DPS_SEL_STOP_PRIO] & s_stop &
		~stop_key_d_r & (src_r != DPS_SRC_KEY) & (run_state_r == DPS_RUN);

	// Operation error: set wins over release
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			op_err_r <= 1'b0;
		else if (stop_sel_r[`DPS_SEL_START_CHK] && check_now && any_run)
			op_err_r <= 1'b1;
		else if (stop_prio_hit)
			op_err_r <= 1'b1;
		else if (alarm_release)
			op_err_r <= 1'b0;
	end
	assign operation_error_alarm = op_err_r;

	// Tenth-second prescaler for break timer
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			tick_cnt_r <= '0;
		else if (tick)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + 32'h1;
	end
	assign tick = (tick_cnt_r == TICK_CYCLES - 1);

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			break_cnt_r <= '0;
		else if (!s_fb_low || break_time_r == 16'h0000)
			break_cnt_r <= '0;
		else if (tick && !break_expired)
			break_cnt_r <= break_cnt_r + 16'h1;
	end
	assign break_expired = (break_cnt_r >= break_time_r);

	assign fan_on = ~ctrl_r[`DPS_CTRL_FAN_ONOFF] | (run_state_r != DPS_IDLE) |
		(src_run & ~tripped);
	assign fan_lock_seen = s_fan & fan_on;

	assign carrier_mode = prot_mode_r[`DPS_PM_CARRIER] & ~ctrl_r[`DPS_CTRL_VECTOR];
	assign hot_event = s_hot | s_ovl;
	assign carrier_lower = carrier_mode & hot_event;

	always_comb
	begin
		trip_set = '0;
		trip_set[0] = s_fb_low & (break_time_r != 16'h0000) & break_expired;
		trip_set[1] = prot_mode_r[`DPS_PM_IN_PHASE] & s_in_pl;
		trip_set[2] = prot_mode_r[`DPS_PM_OUT_PHASE] & s_out_pl &
			(run_state_r == DPS_RUN);
		trip_set[3] = (fan_lock_seen & ~prot_mode_r[`DPS_PM_FAN_RUN_ON]) |
			(s_hot & ~carrier_mode);
		trip_set[4] = prot_mode_r[`DPS_PM_BRAKE] & s_brk;
		trip_set[5] = fan_lock_seen & ~prot_mode_r[`DPS_PM_FAN_RUN_ON];
	end

	// latched trips, set beats release
	// Release loads present causes, so a standing fault relatches
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			trip_r <= '0;
		else if (alarm_release)
			trip_r <= trip_set;
		else
			trip_r <= trip_r | trip_set;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			ovl_trip_r <= 1'b0;
		else if (s_ovl && !carrier_mode)
			ovl_trip_r <= 1'b1;
		else if (alarm_release)
			ovl_trip_r <= 1'b0;
	end

	assign wire_break_alarm = trip_r[0];
	assign input_phase_loss_alarm = trip_r[1];
	assign output_phase_loss_alarm = trip_r[2];
	assign heatsink_overheat_alarm = trip_r[3];
	assign braking_alarm = trip_r[4];
	assign drive_overload_alarm = ovl_trip_r;
	assign tripped = (|trip_r) | ovl_trip_r;

	// Run sequencer
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			run_state_r <= DPS_IDLE;
		else
		begin
			unique case (run_state_r)
				DPS_IDLE:
					if (src_run && !tripped && !op_err_r && !check_now)
						run_state_r <= DPS_RUN;
				DPS_RUN:
					// A trip other than overload in the same cycle drops drive at once
					if (tripped || (|trip_set))
						run_state_r <= DPS_IDLE;
					else if (stop_prio_hit || !src_run)
						run_state_r <= DPS_DECEL;
				DPS_DECEL:
					if (s_stopped || tripped)
						run_state_r <= DPS_IDLE;
				default: run_state_r <= DPS_IDLE;
			endcase
		end
	end

	assign run_enable = (run_state_r == DPS_RUN);
	assign decel_stop = (run_state_r == DPS_DECEL);
	// Any trip removes drive at once
	assign coast_stop = tripped;

	assign overheat_output = fan_lock_seen;
	assign lifetime_output = fan_lock_seen | s_cap_t |
		(prot_mode_r[`DPS_PM_CAP_DISCH] &
		(prot_mode_r[`DPS_PM_CAP_USER] ? s_cap_u : s_cap_f));
	assign enclosure_high_class = prot_mode_r[`DPS_PM_ENCLOSURE];

endmodule

// ===== include/dps_map.svh
/*
 Constants of the drive protection and start interlock block: register
 offsets, field positions, reset values and timing figures.
 Assumes a 20 MHz clock and word-aligned byte offsets.
*/
// Notes on behaviour
// - Feedback current below 2 mA means wire break.
// - Break time 0 disables; else alarm within time.
// - Select: 0 none, 1 stop, 2 check, 3 both.
// - Stop key decelerates remote run, flags operation error.
// - Active run at check refuses start, flags error.
// - Check at power-on, alarm release, source change; the power-on check sees reset synchronisers and select 0, so never flags.
// - History clear erases, then returns to zero.
// - Bit0 without vector control lowers carrier, no trip.
// - Bit1 trips on supply phase loss.
// - Bit2 trips on output phase loss while running.
// - Bit3 picks factory or user capacitor threshold.
// - Bit4 gates discharge judgment; on-time judgment stays.
// - Fan lock trips and coasts unless bit5 set.
// - Fan lock always drives overheat and lifetime outputs.
// - Start forces fan on, then lock is seen.
// - Bit6 trips on braking transistor fault.
// - Protection word is decimal byte, default 83.
// - Bit7 picks lower or higher enclosure class.
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH
`define DPS_OFS_BREAK_TIME 8'h00
`define DPS_OFS_STOP_SEL 8'h04
`define DPS_OFS_HIST_CLR 8'h08
`define DPS_OFS_PROT_MODE 8'h0c
`define DPS_OFS_CTRL 8'h10
`define DPS_OFS_STATUS 8'h14
`define DPS_RST_BREAK_TIME 16'h0000
`define DPS_RST_STOP_SEL 2'h0
`define DPS_RST_PROT_MODE 8'h53
`define DPS_RST_CTRL 2'h0
`define DPS_PM_CARRIER 0
`define DPS_PM_IN_PHASE 1
`define DPS_PM_OUT_PHASE 2
`define DPS_PM_CAP_USER 3
`define DPS_PM_CAP_DISCH 4
`define DPS_PM_FAN_RUN_ON 5
`define DPS_PM_BRAKE 6
`define DPS_PM_ENCLOSURE 7
`define DPS_SEL_STOP_PRIO 0
`define DPS_SEL_START_CHK 1
`define DPS_CTRL_VECTOR 0
`define DPS_CTRL_FAN_ONOFF 1
`define DPS_CLK_PERIOD_NS 50
`define DPS_BREAK_UNIT_MS 100
`endif

// ===== include/dps_pkg.sv
/*
 Types of the drive protection and start interlock block.
 Assumes the constants header is included where offsets are needed.
*/
package dps_pkg;
	typedef enum logic [1:0] {DPS_IDLE, DPS_RUN, DPS_DECEL} dps_run_t;
	typedef enum logic [1:0] {DPS_SRC_TERM, DPS_SRC_KEY, DPS_SRC_LINK} dps_src_t;
endpackage

// ===== bench/dps_protect_assertions.sv
/*
 Port checker of the protection block.
 Assumes it is bound onto every dps_protect.
*/
`timescale 1ns/1ps
module dps_protect_chk (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic alarm_history_clear_pulse,
	input wire logic enclosure_high_class,
	input wire logic fan_on,
	input wire logic fan_locked,
	input wire logic overheat_output,
	input wire logic lifetime_output,
	input wire logic braking_alarm,
	input wire logic alarm_reset_key,
	input wire logic alarm_reset_input,
	input wire logic wire_break_alarm,
	input wire logic input_phase_loss_alarm,
	input wire logic coast_stop,
	input wire logic run_enable,
	input wire logic decel_stop
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	chk_clear_one_cycle: assert property (
		alarm_history_clear_pulse |=> !alarm_history_clear_pulse)
		else $error("clear pulse too long");
	chk_clear_from_write: assert property (
		reg_wr && reg_addr == 8'h08 && reg_wdata[0] |=> alarm_history_clear_pulse)
		else $error("clear pulse missing");
	chk_enclosure_bit: assert property (
		reg_wr && reg_addr == 8'h0c |=> enclosure_high_class == $past(reg_wdata[7]))
		else $error("enclosure class wrong");
	chk_fan_lock_out: assert property (
		(fan_on && fan_locked) [*4] |-> overheat_output && lifetime_output)
		else $error("fan lock outputs low");
	// Five quiet cycles cover the release synchroniser
	chk_trip_hold: assert property (
		(braking_alarm && !alarm_reset_key && !alarm_reset_input) [*5] |=> braking_alarm)
		else $error("trip dropped without release");
	chk_trip_stops: assert property (
		wire_break_alarm || braking_alarm |-> coast_stop && !run_enable)
		else $error("trip without stop");
	chk_phase_stop: assert property (
		input_phase_loss_alarm |-> coast_stop)
		else $error("phase loss without stop");
	chk_decel_from_run: assert property (
		$rose(decel_stop) |-> $past(run_enable))
		else $error("decel entered without run");
endmodule
bind dps_protect dps_protect_chk i_dps_protect_chk (.*);

// ===== bench/dps_src_model.sv
/*
 Run-command sources: terminals, keypad, link, keys.
 Assumes the bench sets want after a rising edge.
*/
`timescale 1ns/1ps
module dps_src_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [5:0] want,
	output logic run_terminal,
	output logic run_keypad,
	output logic run_link,
	output logic stop_key,
	output logic link_enable_input,
	output logic local_select_input
);
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			{local_select_input, link_enable_input, stop_key, run_link, run_keypad,
				run_terminal} <= 6'h00;
		else
			{local_select_input, link_enable_input, stop_key, run_link, run_keypad,
				run_terminal} <= want;
	end
endmodule

// ===== bench/dps_protect_test.sv
/*
 Self-checking bench of the protection block.
 Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ps
module dps_protect_test;
	localparam int T = 10;
	logic clock, arst_n, reg_wr, reg_rd;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [12:0] p;
	logic [5:0] want;
	logic run_terminal, run_keypad, run_link, stop_key, link_enable_input, local_select_input;
	logic run_enable, decel_stop, coast_stop, carrier_lower, fan_on, overheat_output;
	logic lifetime_output, enclosure_high_class, alarm_history_clear_pulse, braking_alarm;
	logic operation_error_alarm, wire_break_alarm, input_phase_loss_alarm;
	logic output_phase_loss_alarm, heatsink_overheat_alarm, drive_overload_alarm;
	int fails, samples_checked, cnt;
	// Pin vector: 0 break,1 key,2 reset,3 stopped,4 hot,5 load,6 supply,7 out,8 fan,9 brake
	dps_protect #(.TICK_CYCLES(T)) i_dps_protect (.*, .fb_below_2ma(p[0]),
		.alarm_reset_key(p[1]), .alarm_reset_input(p[2]), .motor_stopped(p[3]),
		.heatsink_hot(p[4]), .drive_overload(p[5]), .supply_phase_loss(p[6]),
		.output_phase_loss(p[7]), .fan_locked(p[8]), .brake_fault(p[9]),
		.cap_worn_factory(p[10]), .cap_worn_user(p[11]), .cap_ontime_worn(p[12]));
	dps_src_model i_dps_src_model (.*);
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", reg_rdata, e);
	endtask
	task automatic release_alarm();
		// Let earlier pin changes pass the synchroniser first
		cyc(2);
		p[2] <= 1'b1;
		cyc(4);
		p[2] <= 1'b0;
		cyc(6);
	endtask
	task automatic done(string n);
		$display("test %s over", n);
	endtask
	task automatic close_out();
		$display("compared %0d mismatched %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Whole run is well under a thousand cycles
	always @(posedge clock)
	begin
		cnt++;
		if (cnt == 4000)
		begin
			fails++;
			close_out();
		end
	end
	initial
	begin
		arst_n = 1'b0;
		{reg_wr, reg_rd, reg_addr, reg_wdata, want} = '0;
		p = 13'h0008;
		cyc(6);
		arst_n = 1'b1;
		rd(8'h0c, 32'h53);
		rd(8'h04, 32'h0);
		rd(8'h40, 32'h0);
		wr(8'h0c, 32'h80);
		cyc(1);
		chk("enclosure", enclosure_high_class, 1);
		wr(8'h08, 32'h1);
		cyc(0);
		chk("clear_pulse", alarm_history_clear_pulse, 1);
		rd(8'h08, 32'h0);
		wr(8'h0c, 32'h53);
		done("registers");
		wr(8'h04, 32'h3);
		p <= 13'h0;
		want <= 6'h01;
		cyc(8);
		chk("run_enable", run_enable, 1);
		want <= 6'h09;
		cyc(6);
		chk("decel_stop", decel_stop, 1);
		chk("op_error", operation_error_alarm, 1);
		want <= 6'h00;
		p <= 13'h0008;
		release_alarm();
		chk("op_error", operation_error_alarm, 0);
		done("stop priority");
		wr(8'h04, 32'h2);
		want <= 6'h01;
		cyc(6);
		want <= 6'h21;
		cyc(6);
		chk("op_error", operation_error_alarm, 1);
		release_alarm();
		chk("op_error", operation_error_alarm, 1);
		want <= 6'h00;
		release_alarm();
		chk("op_error", operation_error_alarm, 0);
		done("start check");
		wr(8'h00, 32'h0);
		p[0] <= 1'b1;
		cyc(60);
		chk("wire_break", wire_break_alarm, 0);
		wr(8'h00, 32'h2);
		cyc(2 * T + 10);
		chk("wire_break", wire_break_alarm, 1);
		p[0] <= 1'b0;
		cyc(5);
		chk("wire_break", wire_break_alarm, 1);
		release_alarm();
		chk("wire_break", wire_break_alarm, 0);
		done("wire break");
		p[8] <= 1'b1;
		cyc(6);
		chk("heatsink", heatsink_overheat_alarm, 1);
		p[8] <= 1'b0;
		wr(8'h0c, 32'h73);
		release_alarm();
		p[8] <= 1'b1;
		cyc(6);
		chk("heatsink", heatsink_overheat_alarm, 0);
		chk("overheat_out", overheat_output, 1);
		chk("lifetime_out", lifetime_output, 1);
		p[8] <= 1'b0;
		wr(8'h0c, 32'h53);
		p[9:4] <= 6'h25;
		cyc(6);
		chk("braking", braking_alarm, 1);
		chk("in_phase", input_phase_loss_alarm, 1);
		chk("carrier", carrier_lower, 1);
		p[9:4] <= 6'h00;
		wr(8'h0c, 32'h11);
		release_alarm();
		p[9:4] <= 6'h24;
		cyc(6);
		chk("braking", braking_alarm, 0);
		chk("in_phase", input_phase_loss_alarm, 0);
		done("protection word");
		p <= 13'h0808;
		cyc(3);
		wr(8'h0c, 32'h53);
		cyc(1);
		chk("lifetime", lifetime_output, 0);
		wr(8'h0c, 32'h5b);
		cyc(1);
		chk("lifetime", lifetime_output, 1);
		wr(8'h0c, 32'h4b);
		cyc(1);
		chk("lifetime", lifetime_output, 0);
		p[12] <= 1'b1;
		cyc(4);
		chk("lifetime", lifetime_output, 1);
		wr(8'h10, 32'h2);
		cyc(1);
		chk("fan_on", fan_on, 0);
		wr(8'h0c, 32'h57);
		want <= 6'h01;
		cyc(6);
		chk("fan_on", fan_on, 1);
		chk("run_enable", run_enable, 1);
		p[7] <= 1'b1;
		cyc(6);
		chk("out_phase", output_phase_loss_alarm, 1);
		chk("coast_stop", coast_stop, 1);
		chk("run_enable", run_enable, 0);
		want <= 6'h00;
		p <= 13'h0028;
		wr(8'h10, 32'h1);
		cyc(6);
		chk("overload", drive_overload_alarm, 1);
		chk("carrier", carrier_lower, 0);
		p <= 13'h0008;
		release_alarm();
		chk("overload", drive_overload_alarm, 0);
		chk("out_phase", output_phase_loss_alarm, 0);
		done("maintenance");
		close_out();
	end
endmodule
